// File: logic/smbus_cfg_pkg.sv
// Constants and types for the lockable serial configuration register bank
// ============================================================================
// Function
// - Byte write: start, address+W, command, data, stop; acknowledge each byte
// - Byte read: address+W, command, repeated start, address+R, data, host NAK
// - Command MSB one means single byte access; low seven bits are offset
// - Write-disable bit set after write-enable was one locks everything until reset
// - When permanently locked, writes are still acknowledged but change nothing
// - Write-enable one unlocks configuration; zero relocks all bits but itself
// - Writes made while locked complete with acknowledges but alter nothing except the write-enable and write-disable bits
// - Write-enable change to the configuration lock takes effect only from the next block write
// - Byte zero bits four to one hold frequency select, loaded from straps
// - Output enable bits drive outputs when one; all reset to one
// - Respond only to the fixed seven-bit device address
// ============================================================================
`default_nettype none
package smbus_cfg_pkg;

  // Bus address and register offsets
  localparam logic [6:0] DEV_ADDR          = 7'h69;
  localparam logic [6:0] REG_FREQ_LOCK_OFS = 7'h00;
  localparam logic [6:0] REG_PCI_EN_OFS    = 7'h01;
  localparam logic [7:0] BLOCK_BYTE_COUNT  = 8'h02;

  // Field positions of byte zero
  localparam int WDIS_BIT = 7;
  localparam int TEST_BIT = 6;
  localparam int EN7_BIT  = 5;
  localparam int FS_MSB   = 4;
  localparam int FS_LSB   = 1;
  localparam int WEN_BIT  = 0;
  // Field position of byte one enables
  localparam int PCI_MSB  = 7;
  localparam int PCI_LSB  = 2;

  // Values after reset
  localparam logic       WEN_RST  = 1'b0;
  localparam logic       WDIS_RST = 1'b0;
  localparam logic       TEST_RST = 1'b0;
  localparam logic       EN7_RST  = 1'b1;
  localparam logic [5:0] PCI_RST  = 6'h3F;

  // Bit count at which a byte is complete
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  // Serial engine states and byte positions
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} state_t;
  typedef enum logic [1:0] {POS_ADDR, POS_CMD, POS_DATA} pos_t;

endpackage // smbus_cfg_pkg
`default_nettype wire

// File: logic/pin_sync_chain.sv
// Two-stage synchroniser for pin inputs with a delayed copy for edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync_chain
#(
  parameter int WIDTH = 6
)
(
  // Clock
  input  wire logic             i_clk,
  // Asynchronous pins
  input  wire logic [WIDTH-1:0] i_pins,
  // Synchronised level and its one-cycle delayed copy
  output logic      [WIDTH-1:0] o_sync,
  output logic      [WIDTH-1:0] o_dly
);

  // ==========================================================================
  // Per-bit flip-flop chain
  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1)
    begin : g_bit
      logic meta_ff;
      logic sync_ff;
      logic dly_ff;
      // First stage feeds only the second stage
      always_ff @(posedge i_clk)
      begin
        meta_ff <= i_pins[b];
        sync_ff <= meta_ff;
        dly_ff  <= sync_ff;
      end
      assign o_sync[b] = sync_ff;
      assign o_dly[b]  = dly_ff;
    end
  endgenerate

endmodule // pin_sync_chain
`default_nettype wire

// File: logic/smbus_config_regs_lockable.sv
// Serial bus slave with lockable frequency and clock enable registers
`timescale 1ns/1ps
`default_nettype none
module smbus_config_regs_lockable
  import smbus_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Serial bus pins (data is open drain)
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_en_n,
  // Frequency select straps
  input  wire logic [3:0] i_fs_strap,
  // Synthesis and output gating controls
  output logic [3:0]      o_freq_select,
  output logic            o_bus_clock_out_seven_en,
  output logic            o_bus_clock_free_running_out_en,
  output logic            o_bus_clock_out_six_en,
  output logic            o_bus_clock_out_five_en,
  output logic            o_bus_clock_out_four_en,
  output logic            o_bus_clock_out_three_en,
  output logic            o_bus_clock_out_two_en
);

  // Assertion clock and reset shared by every property below
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ==========================================================================
  // Pin synchronisation
  logic [5:0] pin_s;
  logic [5:0] pin_d;

  pin_sync_chain #(.WIDTH(6)) u_sync
  (
    .i_clk  (i_clk),
    .i_pins ({i_fs_strap, i_sda, i_scl}),
    .o_sync (pin_s),
    .o_dly  (pin_d)
  );

  // ==========================================================================
  // Declarations
  state_t     state_ff;
  pos_t       pos_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [6:0] ptr_ff;
  logic       cnt_pend_ff;
  logic       blk_ff;
  logic       rd_mode_ff;
  logic       mack_ff;
  logic       we_ff;
  logic       wdis_ff;
  logic       test_ff;
  logic       en7_ff;
  logic [3:0] fs_ff;
  logic [5:0] pci_en_ff;
  logic       unlock_ff;

  // ==========================================================================
  // Bus condition decode
  wire       scl_s     = pin_s[0];
  wire       sda_s     = pin_s[1];
  wire       scl_d     = pin_d[0];
  wire       sda_d     = pin_d[1];
  wire [3:0] strap_s   = pin_s[5:2];
  wire       start_evt = scl_s & sda_d & ~sda_s;
  wire       stop_evt  = scl_s & ~sda_d & sda_s;
  wire       scl_rise  = scl_s & ~scl_d;
  wire       scl_fall  = ~scl_s & scl_d;

  // Byte completion events
  wire byte_done  = (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
  wire addr_hit   = (shift_ff[7:1] == DEV_ADDR);
  wire addr_evt   = byte_done && (pos_ff == POS_ADDR) && addr_hit;
  wire cmd_evt    = byte_done && (pos_ff == POS_CMD);
  wire data_evt   = byte_done && (pos_ff == POS_DATA);
  wire wr_evt     = data_evt && !cnt_pend_ff;
  wire unlock_upd = data_evt && cnt_pend_ff;
  wire ack_next   = (state_ff == ST_TXACK) && scl_fall && mack_ff;

  // Write qualification by lock state
  wire allow_cfg  = unlock_ff & ~wdis_ff;
  wire wr_b0      = wr_evt && (ptr_ff == REG_FREQ_LOCK_OFS) && !wdis_ff;
  wire wr_b0_cfg  = wr_b0 && allow_cfg;
  wire wr_b1      = wr_evt && (ptr_ff == REG_PCI_EN_OFS) && allow_cfg;
  wire wdis_set   = wr_b0 && shift_ff[WDIS_BIT] && we_ff;

  // Read data selection
  wire [7:0] rd_b0 = {wdis_ff, test_ff, en7_ff, fs_ff, we_ff};
  wire [7:0] rd_b1 = {pci_en_ff, 2'h0};
  wire [7:0] rd_at_ptr = (ptr_ff == REG_FREQ_LOCK_OFS) ? rd_b0 :
                         (ptr_ff == REG_PCI_EN_OFS)    ? rd_b1 : 8'h00;

  // ==========================================================================
  // Serial engine: receive, acknowledge, transmit
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_ff   <= ST_IDLE;
      pos_ff     <= POS_ADDR;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      tx_ff      <= 8'h00;
      rd_mode_ff <= 1'b0;
      mack_ff    <= 1'b0;
    end
    else if (start_evt)
    begin
      state_ff   <= ST_RX;
      pos_ff     <= POS_ADDR;
      bit_cnt_ff <= 4'h0;
    end
    else if (stop_evt)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_RX:
        begin
          if (scl_rise && (bit_cnt_ff != BITS_PER_BYTE))
          begin
            shift_ff   <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (byte_done)
          begin
            if ((pos_ff == POS_ADDR) && !addr_hit)
              state_ff <= ST_IDLE;
            else
              state_ff <= ST_ACK;
            if (addr_evt)
            begin
              rd_mode_ff <= shift_ff[0];
              tx_ff      <= blk_ff ? BLOCK_BYTE_COUNT : rd_at_ptr;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_ff <= 4'h0;
            if (rd_mode_ff)
              state_ff <= ST_TX;
            else
            begin
              state_ff <= ST_RX;
              pos_ff   <= (pos_ff == POS_ADDR) ? POS_CMD : POS_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_ff == LAST_TX_BIT)
              state_ff <= ST_TXACK;
            tx_ff      <= {tx_ff[6:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
            mack_ff <= ~sda_s;
          else if (scl_fall)
          begin
            bit_cnt_ff <= 4'h0;
            if (mack_ff)
            begin
              state_ff <= ST_TX;
              tx_ff    <= rd_at_ptr;
            end
            else
              state_ff <= ST_IDLE;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Offset pointer and block byte-count tracking
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ptr_ff      <= 7'h00;
      cnt_pend_ff <= 1'b0;
      blk_ff      <= 1'b0;
    end
    else if (cmd_evt)
    begin
      ptr_ff      <= shift_ff[7] ? shift_ff[6:0] : 7'h00;
      cnt_pend_ff <= ~shift_ff[7];
      blk_ff      <= ~shift_ff[7];
    end
    else if (unlock_upd)
      cnt_pend_ff <= 1'b0;
    else if (wr_evt || ack_next || (addr_evt && shift_ff[0] && !blk_ff))
      ptr_ff <= ptr_ff + 7'h01;
  end

  // ==========================================================================
  // Configuration registers with write protection
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      we_ff     <= WEN_RST;
      wdis_ff   <= WDIS_RST;
      test_ff   <= TEST_RST;
      en7_ff    <= EN7_RST;
      fs_ff     <= strap_s;
      pci_en_ff <= PCI_RST;
      unlock_ff <= 1'b0;
    end
    else
    begin
      if (wr_b0)
        we_ff <= shift_ff[WEN_BIT];
      if (wdis_set)
        wdis_ff <= 1'b1;
      if (wr_b0_cfg)
      begin
        test_ff <= shift_ff[TEST_BIT];
        en7_ff  <= shift_ff[EN7_BIT];
        fs_ff   <= shift_ff[FS_MSB:FS_LSB];
      end
      if (wr_b1)
        pci_en_ff <= shift_ff[PCI_MSB:PCI_LSB];
      if (unlock_upd)
        unlock_ff <= we_ff;
    end
  end

  // ==========================================================================
  // Pin and control outputs
  assign o_sda_out  = 1'b0;
  assign o_sda_en_n = ~((state_ff == ST_ACK) || ((state_ff == ST_TX) && !tx_ff[7]));
  assign o_freq_select                   = fs_ff;
  assign o_bus_clock_out_seven_en        = en7_ff;
  assign o_bus_clock_free_running_out_en = pci_en_ff[5];
  assign o_bus_clock_out_six_en          = pci_en_ff[4];
  assign o_bus_clock_out_five_en         = pci_en_ff[3];
  assign o_bus_clock_out_four_en         = pci_en_ff[2];
  assign o_bus_clock_out_three_en        = pci_en_ff[1];
  assign o_bus_clock_out_two_en          = pci_en_ff[0];

  // ==========================================================================
  // Assertions

  sequence s_byte_end;
    (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
  endsequence

  sequence s_ack_slot;
    (state_ff == ST_ACK) && !o_sda_en_n;
  endsequence

  write_ack_a: assert property (s_byte_end and (pos_ff == POS_DATA) |=> s_ack_slot)
    else $error("data byte not acknowledged");
  addr_miss_a: assert property (s_byte_end and (pos_ff == POS_ADDR) && !addr_hit |=> state_ff == ST_IDLE)
    else $error("foreign address acknowledged");
  lock_hold_a: assert property (wdis_ff |=> $stable(rd_b0) && $stable(pci_en_ff))
    else $error("register changed while write disabled");
  locked_write_a: assert property (wr_evt && !allow_cfg |=> $stable(fs_ff) && $stable(pci_en_ff) && $stable(en7_ff))
    else $error("locked write altered configuration");
  disable_set_a: assert property (wr_b0 && shift_ff[WDIS_BIT] && we_ff |=> wdis_ff [*2])
    else $error("write disable not latched");
  unlock_defer_a: assert property ($changed(unlock_ff) |-> $past(unlock_upd))
    else $error("unlock changed outside block write");
  cmd_offset_a: assert property (cmd_evt && shift_ff[7] |=> ptr_ff == $past(shift_ff[6:0]))
    else $error("byte offset not taken from command");
  reset_default_a: assert property ($past(i_reset) |-> pci_en_ff == PCI_RST && en7_ff && o_freq_select == $past(strap_s))
    else $error("wrong values after reset");
  enable_out_a: assert property (wr_b1 |=> o_bus_clock_free_running_out_en == $past(shift_ff[7]))
    else $error("enable output not following register");

endmodule // smbus_config_regs_lockable
`default_nettype wire

// File: test/smbus_host_model.sv
// Host controller model that drives the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
(
  // Clock
  input  wire logic i_clk,
  // Resolved data line
  input  wire logic i_sda,
  // Pin drives, zero pulls the line low
  output logic      o_scl,
  output logic      o_sda
);
  // Idle bus: both lines released
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Wait cycles; pins move at the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start();
    tick(4);
    o_sda = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b0;
    tick(8);
    o_scl = 1'b0;
  endtask

  // Stop: data rises while clock is high
  task automatic stop();
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b1;
    tick(8);
  endtask

  // One bit: data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    tick(4);
    o_sda = b;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    s = i_sda;
    tick(4);
    o_scl = 1'b0;
  endtask

  // Byte out MSB first (FF to read), then ninth bit: ack seen or host reply
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(nak, ack);
  endtask
endmodule // smbus_host_model
`default_nettype wire

// File: test/smbus_config_regs_lockable_tb.sv
// Self-checking bench for the lockable serial configuration registers
`timescale 1ns/1ps
`default_nettype none
module smbus_config_regs_lockable_tb
  import smbus_cfg_pkg::*;
;
  logic            i_clk;
  logic            i_reset;
  logic      [3:0] strap;
  wire logic       scl;
  wire logic       sda_h;
  wire logic       sda_out;
  wire logic       sda_en_n;
  wire logic       sda;
  wire logic [3:0] fs_out;
  wire logic [6:0] ens;
  int              n_errors;
  int              compares;
  localparam logic [7:0] WA = {DEV_ADDR, 1'b0};

  // Open-drain data line with pull-up
  assign sda = sda_h & (sda_en_n | sda_out);

  smbus_host_model smbus_host_model_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));

  smbus_config_regs_lockable smbus_config_regs_lockable_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_en_n(sda_en_n), .i_fs_strap(strap), .o_freq_select(fs_out),
    .o_bus_clock_out_seven_en(ens[6]), .o_bus_clock_free_running_out_en(ens[5]),
    .o_bus_clock_out_six_en(ens[4]), .o_bus_clock_out_five_en(ens[3]),
    .o_bus_clock_out_four_en(ens[2]), .o_bus_clock_out_three_en(ens[1]),
    .o_bus_clock_out_two_en(ens[0]));

  // Clock at 250 MHz
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Compare one byte-wide result
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Write transaction: start, bytes with ack check, stop
  task automatic wr(input logic [7:0] b[$], input logic ack_exp);
    logic [7:0] q;
    logic       ack;
    smbus_host_model_inst.start();
    foreach (b[i])
    begin
      smbus_host_model_inst.xfer(b[i], 1'b1, q, ack);
      check("write ack", {7'h00, ack_exp}, {7'h00, ack});
    end
    smbus_host_model_inst.stop();
  endtask

  // Byte read with repeated start and closing not-acknowledge
  task automatic rd(input logic [6:0] ofs, input logic [7:0] exp);
    logic [7:0] q;
    logic       ack;
    smbus_host_model_inst.start();
    smbus_host_model_inst.xfer(WA, 1'b1, q, ack);
    smbus_host_model_inst.xfer({1'b1, ofs}, 1'b1, q, ack);
    smbus_host_model_inst.start();
    smbus_host_model_inst.xfer({DEV_ADDR, 1'b1}, 1'b1, q, ack);
    check("read ack", 8'h00, {7'h00, ack});
    smbus_host_model_inst.xfer(8'hFF, 1'b1, q, ack);
    smbus_host_model_inst.stop();
    check("read data", exp, q);
  endtask

  // Block read: count byte, then bytes zero and one, host acknowledges all but the last
  task automatic rd_blk(input logic [7:0] exp0, input logic [7:0] exp1);
    logic [7:0] q;
    logic       ack;
    smbus_host_model_inst.start();
    smbus_host_model_inst.xfer(WA, 1'b1, q, ack);
    smbus_host_model_inst.xfer(8'h00, 1'b1, q, ack);
    smbus_host_model_inst.start();
    smbus_host_model_inst.xfer({DEV_ADDR, 1'b1}, 1'b1, q, ack);
    check("block read ack", 8'h00, {7'h00, ack});
    smbus_host_model_inst.xfer(8'hFF, 1'b0, q, ack);
    check("block count", BLOCK_BYTE_COUNT, q);
    smbus_host_model_inst.xfer(8'hFF, 1'b0, q, ack);
    check("block byte zero", exp0, q);
    smbus_host_model_inst.xfer(8'hFF, 1'b1, q, ack);
    check("block byte one", exp1, q);
    smbus_host_model_inst.stop();
  endtask

  // Control outputs against expected select code and enables
  task automatic outs(input logic [3:0] f, input logic [6:0] e);
    check("freq select", {4'h0, f}, {4'h0, fs_out});
    check("enables", {1'b0, e}, {1'b0, ens});
  endtask

  // Synchronous reset held for 8 cycles
  task automatic do_reset();
    i_reset = 1'b1;
    repeat (8) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #360000;
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    n_errors = 0;
    compares = 0;
    strap = 4'hA;
    do_reset();
    rd(7'h00, 8'h34);
    rd(7'h01, 8'hFC);
    outs(4'hA, 7'h7F);
    wr('{WA, 8'h81, 8'h00}, 1'b0);
    rd(7'h01, 8'hFC);
    wr('{8'hAA, 8'h81, 8'h00}, 1'b1);
    wr('{WA, 8'h80, 8'h01}, 1'b0);
    rd(7'h00, 8'h35);
    wr('{WA, 8'h81, 8'h00}, 1'b0);
    rd(7'h01, 8'hFC);
    wr('{WA, 8'h00, 8'h02, 8'h0B, 8'h50}, 1'b0);
    rd(7'h00, 8'h0B);
    rd(7'h01, 8'h50);
    outs(4'h5, 7'h14);
    wr('{WA, 8'h80, 8'h0A}, 1'b0);
    wr('{WA, 8'h81, 8'h54}, 1'b0);
    rd(7'h01, 8'h54);
    wr('{WA, 8'h00, 8'h02}, 1'b0);
    wr('{WA, 8'h81, 8'hFC}, 1'b0);
    rd(7'h01, 8'h54);
    wr('{WA, 8'h80, 8'h0B}, 1'b0);
    rd(7'h00, 8'h0B);
    wr('{WA, 8'h80, 8'h8B}, 1'b0);
    rd(7'h00, 8'h8B);
    wr('{WA, 8'h00, 8'h02, 8'h00, 8'h00}, 1'b0);
    wr('{WA, 8'h80, 8'h0A}, 1'b0);
    rd(7'h00, 8'h8B);
    rd(7'h01, 8'h54);
    strap = 4'h3; // Straps only count while reset is held
    rd_blk(8'h8B, 8'h54);
    outs(4'h5, 7'h15);
    do_reset();
    rd(7'h00, 8'h26);
    rd(7'h01, 8'hFC);
    rd(7'h05, 8'h00);
    outs(4'h3, 7'h7F);
    end_of_test();
  end
endmodule // smbus_config_regs_lockable_tb
`default_nettype wire
